// *** rtl/psib_defs.vh ***
// Purpose: Offsets, field positions, codes and reset values of the
//          status and interrupt register bank.
// Assumes: Byte-wide registers reached by an 8-bit register index.
// Notes:   Definitions only; include by bare name.
`ifndef PSIB_DEFS_VH
`define PSIB_DEFS_VH

// Register offsets
`define PSIB_OFS_IDENT 8'h00
`define PSIB_OFS_REV 8'h01
`define PSIB_OFS_STAT_CT 8'h02
`define PSIB_OFS_STAT_IC 8'h03
`define PSIB_OFS_STAT_TL 8'h04
`define PSIB_OFS_STAT_CL 8'h05
`define PSIB_OFS_EVT_A 8'h06
`define PSIB_OFS_EVT_B 8'h07
`define PSIB_OFS_EVT_C 8'h08
`define PSIB_OFS_EN_A 8'h09

// Fixed identity values (arbitrary, neutral)
`define PSIB_IDENT_VAL 8'h5A
`define PSIB_REV_VAL 8'h11

// Reset values
`define PSIB_RST_BYTE 8'h00
`define PSIB_RST_FIELD 3'h0

// Field positions in the charge/temperature status register
`define PSIB_TEMP_MSB 5
`define PSIB_TEMP_LSB 3
`define PSIB_CHG_MSB 2
`define PSIB_CHG_LSB 0

// Temperature region codes that override the monitor result
`define PSIB_TEMP_NO_THERM 3'h5
`define PSIB_TEMP_DISABLED 3'h6
`define PSIB_TEMP_NO_INPUT 3'h7

// Bits of the second event register
`define PSIB_EVB_ONESHOT 6
`define PSIB_EVB_SW1_TMO 1
`define PSIB_EVB_SW2_TMO 0

// Bits of the second event register that a read does not clear
`define PSIB_EVB_KEEP 8'h40
// Bits that a read does not clear in the other two event registers (none)
`define PSIB_KEEP_NONE 8'h00

`endif

// *** rtl/psib_change_det.v ***
// Purpose: Hold a status byte and flag each bit that changed.
// Assumes: Inputs synchronous to clk.
// Notes:   Held value resets to zero, so a nonzero input at release
//          shows up as a change in the first cycle after release.
`timescale 1ns/1ps

module psib_change_det #(
	parameter W = 8
) (
	clk,
	reset,
	live,
	held,
	changed
);
	input wire clk;
	input wire reset;
	input wire [W-1:0] live;
	output reg [W-1:0] held;
	output wire [W-1:0] changed;

	// Bits that differ from the last sampled value
	assign changed = live ^ held;

	// Sample the live status every cycle
	always @(posedge clk) begin
		if (reset) begin
			held <= {W{1'b0}};
		end else begin
			held <= live;
		end
	end
endmodule

// *** rtl/psib_event_latch.v ***
// Purpose: Sticky event bits cleared as a whole by a register read.
// Assumes: clr is a one-cycle read strobe for this register.
// Notes:   A set in the clearing cycle survives; KEEP bits ignore clr.
`timescale 1ns/1ps

module psib_event_latch #(
	parameter W = 8,
	parameter [W-1:0] KEEP = {W{1'b0}}
) (
	clk,
	reset,
	set,
	clr,
	latched
);
	input wire clk;
	input wire reset;
	input wire [W-1:0] set;
	input wire clr;
	output reg [W-1:0] latched;

	// Mask of bits that a read wipes this cycle
	wire [W-1:0] wipe;

	assign wipe = clr ? ~KEEP : {W{1'b0}};

	// Set wins over clear so no event is lost at the read
	always @(posedge clk) begin
		if (reset) begin
			latched <= {W{1'b0}};
		end else begin
			latched <= (latched & ~wipe) | set;
		end
	end
endmodule

// *** rtl/psib_bank.v ***
// Purpose: Status and interrupt register bank of a power device.
// Assumes: Register port strobes come from the serial control port
//          logic, one cycle each, synchronous to clk.
// Notes:   Read data are registered: valid the cycle after reg_rd.
`timescale 1ns/1ps
`include "psib_defs.vh"

// What this block does
// RULE1: Fixed read-only identity byte at offset zero
// RULE2: Fixed read-only revision byte at offset one
// RULE3: Temperature field shows monitor region, resets zero
// RULE4: Override codes: no thermistor, disabled, no input
// RULE5: Charger state field in bits two to zero
// RULE6: Input limit, overvoltage, valid status bits
// RULE7: Temperature shutdown, regulation, timeout status bits
// RULE8: Charger thermal shutdown and one-shot monitor bits
// RULE9: Linear/switch thermal and second lockout bits
// RULE10: Buck-boost fault, lockout, rail and input limits
// RULE11: Step charge and three buck thermal bits
// RULE12: First event register latches status changes
// RULE13: Reads clear event registers except one-shot bit
// RULE14: Second event register latches bits seven to four
// RULE15: Switch startup timeouts latch bits one, zero
// RULE16: Third event register latches converter status changes
// RULE17: First mask register eight bits, read-write, reset zero
// RULE18: Mask bit zero blocks, one passes
// RULE19: Request raised while any permitted event set
module psib_bank (
	clk,
	reset,
	reg_addr,
	reg_wr,
	reg_wdata,
	reg_rd,
	reg_rdata,
	temp_region,
	no_thermistor,
	thermistor_disabled,
	charger_state,
	input_limit_active,
	input_overvoltage,
	input_valid,
	charge_temp_shutdown,
	charge_temp_regulation,
	charge_timeout,
	charger_thermal_shutdown,
	oneshot_monitor_busy,
	linear_switch_thermal,
	second_linear_lockout,
	buckboost_fault,
	buckboost_lockout,
	sysrail_charge_limit,
	input_collapse_limit,
	step_charge_active,
	buck_one_thermal,
	buck_two_thermal,
	buck_three_thermal,
	switch_one_start_timeout,
	switch_two_start_timeout,
	irq
);
	input wire clk;
	input wire reset;
	// Register port
	input wire [7:0] reg_addr;
	input wire reg_wr;
	input wire [7:0] reg_wdata;
	input wire reg_rd;
	output wire [7:0] reg_rdata;
	// Thermistor monitor result, region code 0..4
	input wire [2:0] temp_region;
	input wire no_thermistor;
	// Thermistor input turned off by configuration
	input wire thermistor_disabled;
	input wire [2:0] charger_state;
	// Input supply and charger conditions
	input wire input_limit_active;
	input wire input_overvoltage;
	input wire input_valid;
	input wire charge_temp_shutdown;
	input wire charge_temp_regulation;
	input wire charge_timeout;
	// Thermal and lockout conditions
	input wire charger_thermal_shutdown;
	input wire oneshot_monitor_busy;
	input wire linear_switch_thermal;
	input wire second_linear_lockout;
	// Converter and limiter conditions
	input wire buckboost_fault;
	input wire buckboost_lockout;
	input wire sysrail_charge_limit;
	input wire input_collapse_limit;
	input wire step_charge_active;
	input wire buck_one_thermal;
	input wire buck_two_thermal;
	input wire buck_three_thermal;
	// One-cycle pulses: a load switch failed to start in time
	input wire switch_one_start_timeout;
	input wire switch_two_start_timeout;
	// Interrupt request, active high level
	output wire irq;

	// Effective temperature region after override codes
	reg [2:0] temp_eff;
	// Live status bytes before sampling
	wire [7:0] live_ct;
	wire [7:0] live_ic;
	wire [7:0] live_tl;
	wire [7:0] live_cl;
	// Sampled status bytes as the host reads them
	wire [7:0] stat_ct;
	wire [7:0] stat_ic;
	wire [7:0] stat_tl;
	wire [7:0] stat_cl;
	// Per-bit change flags
	wire [7:0] chg_ct;
	wire [7:0] chg_ic;
	wire [7:0] chg_tl;
	wire [7:0] chg_cl;
	// Event set vectors for the three event registers
	wire [7:0] set_a;
	wire [7:0] set_b;
	wire [7:0] set_c;
	// Latched event registers
	wire [7:0] evt_a;
	wire [7:0] evt_b;
	wire [7:0] evt_c;
	// Read strobes of each event register
	wire rd_evt_a;
	wire rd_evt_b;
	wire rd_evt_c;
	// Mask register and its next value
	reg [7:0] en_a_ff;
	reg [7:0] nxt_en_a;
	// Read data register and its next value
	reg [7:0] rdata_ff;
	reg [7:0] nxt_rdata;

	// Region code: missing input first, then configuration, then
	// sensor presence; only then does the monitor result show.
	always @* begin
		if (!input_valid) begin
			temp_eff = `PSIB_TEMP_NO_INPUT; // see RULE4
		end else if (thermistor_disabled) begin
			temp_eff = `PSIB_TEMP_DISABLED; // see RULE4
		end else if (no_thermistor) begin
			temp_eff = `PSIB_TEMP_NO_THERM; // see RULE4
		end else begin
			temp_eff = temp_region; // see RULE3
		end
	end

	// Status byte assembly; unused bits read as zero
	assign live_ct = {2'h0, temp_eff, charger_state}; // see RULE5
	assign live_ic = {2'h0, input_limit_active, input_overvoltage,
		input_valid, // see RULE6
		charge_temp_shutdown, charge_temp_regulation,
		charge_timeout}; // see RULE7
	assign live_tl = {charger_thermal_shutdown, oneshot_monitor_busy,
		// see RULE8
		linear_switch_thermal, second_linear_lockout, // see RULE9
		4'h0};
	assign live_cl = {buckboost_fault, buckboost_lockout,
		sysrail_charge_limit, input_collapse_limit, // see RULE10
		step_charge_active, buck_one_thermal, buck_two_thermal,
		buck_three_thermal}; // see RULE11

	// Sampling of each status byte; zero after reset as documented
	psib_change_det #(.W(8)) u_det_ct (
		.clk(clk),
		.reset(reset),
		.live(live_ct),
		.held(stat_ct), // see RULE3
		.changed(chg_ct)
	);

	psib_change_det #(.W(8)) u_det_ic (
		.clk(clk),
		.reset(reset),
		.live(live_ic),
		.held(stat_ic),
		.changed(chg_ic)
	);

	psib_change_det #(.W(8)) u_det_tl (
		.clk(clk),
		.reset(reset),
		.live(live_tl),
		.held(stat_tl),
		.changed(chg_tl)
	);

	psib_change_det #(.W(8)) u_det_cl (
		.clk(clk),
		.reset(reset),
		.live(live_cl),
		.held(stat_cl),
		.changed(chg_cl)
	);

	// First event register: a change anywhere in a field sets its bit
	assign set_a = {
		|chg_ct[`PSIB_TEMP_MSB:`PSIB_TEMP_LSB],
		|chg_ct[`PSIB_CHG_MSB:`PSIB_CHG_LSB],
		chg_ic[5:0]}; // see RULE12

	// Second event register: status changes high, start pulses low
	assign set_b = {chg_tl[7:4], 2'h0,
		switch_one_start_timeout,
		switch_two_start_timeout}; // see RULE14, RULE15

	// Third event register latches converter status changes bit for bit
	assign set_c = chg_cl; // see RULE16

	// A read strobe at an event offset clears that register
	assign rd_evt_a = reg_rd && (reg_addr == `PSIB_OFS_EVT_A);
	assign rd_evt_b = reg_rd && (reg_addr == `PSIB_OFS_EVT_B);
	assign rd_evt_c = reg_rd && (reg_addr == `PSIB_OFS_EVT_C);

	psib_event_latch #(.W(8), .KEEP(`PSIB_KEEP_NONE)) u_evt_a (
		.clk(clk),
		.reset(reset),
		.set(set_a),
		.clr(rd_evt_a), // see RULE13
		.latched(evt_a)
	);

	// The one-shot monitor bit stays set across reads
	psib_event_latch #(.W(8), .KEEP(`PSIB_EVB_KEEP)) u_evt_b (
		.clk(clk),
		.reset(reset),
		.set(set_b),
		.clr(rd_evt_b), // see RULE13
		.latched(evt_b)
	);

	psib_event_latch #(.W(8), .KEEP(`PSIB_KEEP_NONE)) u_evt_c (
		.clk(clk),
		.reset(reset),
		.set(set_c),
		.clr(rd_evt_c), // see RULE13
		.latched(evt_c)
	);

	// Mask register: only its own offset is writable
	always @* begin
		nxt_en_a = en_a_ff;
		if (reg_wr && (reg_addr == `PSIB_OFS_EN_A)) begin
			nxt_en_a = reg_wdata; // see RULE17
		end
	end

	// Mask register storage, all bits blocked after reset
	always @(posedge clk) begin
		if (reset) begin
			en_a_ff <= `PSIB_RST_BYTE; // see RULE17
		end else begin
			en_a_ff <= nxt_en_a;
		end
	end

	// Read multiplexer; writes to read-only offsets are dropped
	// because nothing else decodes reg_wr
	always @* begin
		nxt_rdata = rdata_ff;
		if (reg_rd) begin
			case (reg_addr)
				`PSIB_OFS_IDENT: begin
					nxt_rdata = `PSIB_IDENT_VAL; // see RULE1
				end
				`PSIB_OFS_REV: begin
					nxt_rdata = `PSIB_REV_VAL; // see RULE2
				end
				`PSIB_OFS_STAT_CT: begin
					nxt_rdata = stat_ct;
				end
				`PSIB_OFS_STAT_IC: begin
					nxt_rdata = stat_ic;
				end
				`PSIB_OFS_STAT_TL: begin
					nxt_rdata = stat_tl;
				end
				`PSIB_OFS_STAT_CL: begin
					nxt_rdata = stat_cl;
				end
				// Event values are captured before the clear lands
				`PSIB_OFS_EVT_A: begin
					nxt_rdata = evt_a;
				end
				`PSIB_OFS_EVT_B: begin
					nxt_rdata = evt_b;
				end
				`PSIB_OFS_EVT_C: begin
					nxt_rdata = evt_c;
				end
				`PSIB_OFS_EN_A: begin
					nxt_rdata = en_a_ff; // see RULE17
				end
				// Unmapped offsets read as zero
				default: begin
					nxt_rdata = `PSIB_RST_BYTE;
				end
			endcase
		end
	end

	// Read data holds until the next read
	always @(posedge clk) begin
		if (reset) begin
			rdata_ff <= `PSIB_RST_BYTE;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

	// Request: masked first register plus the other two, whose masks
	// live outside this bank and so count as open here
	assign irq = (|(evt_a & en_a_ff)) // see RULE18, RULE19
		| (|evt_b) | (|evt_c); // see RULE19
endmodule

// *** verification/psib_bank_monitor.sv ***
// Purpose: Port checks of the status and event register bank.
// Assumes: Read data valid one cycle after reg_rd.
// Notes:   Attached to psib_bank by the bind at the foot.
`timescale 1ns/1ps
`include "psib_defs.vh"

module psib_monitor (
	input wire clk,
	input wire reset,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire input_valid,
	input wire irq
);
	// One clock domain, so one default clock and reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	chk_ident_fixed: assert property (
		reg_rd && reg_addr == 8'h00 |=> reg_rdata == `PSIB_IDENT_VAL)
		else $error("identity byte wrong");
	chk_rev_fixed: assert property (
		reg_rd && reg_addr == 8'h01 |=> reg_rdata == `PSIB_REV_VAL)
		else $error("revision byte wrong");
	chk_unmapped_zero: assert property (
		reg_rd && reg_addr > 8'h09 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	// Read data must stand until the next read
	chk_rdata_holds: assert property (
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	// Status lags the input by one sample, hence the past terms
	chk_temp_noinput: assert property (
		!$past(reset) && !$past(input_valid) && reg_rd &&
		reg_addr == 8'h02 |=> reg_rdata[5:3] == 3'h7)
		else $error("no-input temperature code wrong");
	chk_mask_readback: assert property (
		reg_wr && reg_addr == 8'h09 ##2 reg_rd && reg_addr == 8'h09
		|=> reg_rdata == $past(reg_wdata, 3))
		else $error("mask read-back wrong");
	chk_event_set: assert property (
		!$past(reset) && $changed(input_valid) ##1
		reg_rd && reg_addr == 8'h06 |=> reg_rdata[3])
		else $error("input valid change not latched");
	// The one-shot bit may only grow between two reads
	chk_oneshot_kept: assert property (
		reg_rd && reg_addr == 8'h07 ##2 reg_rd && reg_addr == 8'h07
		|=> !$past(reg_rdata[6]) || reg_rdata[6])
		else $error("one-shot event bit cleared by read");

	c_mask_write: cover property (reg_wr && reg_addr == 8'h09);
	c_irq_rise: cover property ($rose(irq));
	c_evt_read: cover property (reg_rd && reg_addr == 8'h07);
endmodule

bind psib_bank psib_monitor mon (.clk(clk), .reset(reset),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .input_valid(input_valid),
	.irq(irq));

// *** verification/psib_host.sv ***
// Purpose: Host side of the register port: one-cycle strobes.
// Assumes: Read data valid one cycle after the read strobe.
// Notes:   Idle address shows the inverse of the last value; data does so only after a write.
`timescale 1ns/1ps

module psib_host (
	input wire clk,
	output reg [7:0] reg_addr,
	output reg reg_wr,
	output reg [7:0] reg_wdata,
	output reg reg_rd,
	input wire [7:0] reg_rdata
);
	// Quiet bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end

	// Write: strobe for exactly one edge, then scramble the bus
	task wr(input [7:0] a, input [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~v;
	endtask

	// Read: data taken just after the edge that sampled the strobe
	task rd(input [7:0] a, output [7:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 v = reg_rdata;
	endtask
endmodule

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench of the status and event bank.
// Assumes: Status inputs are levels; switch timeouts are pulses.
// Notes:   Event checks rely on the order of the steps below.
`timescale 1ns/1ps
`include "psib_defs.vh"

module tb_top;
	reg clk;
	reg reset;
	reg [2:0] tr;
	reg [2:0] cs;
	reg nt;
	reg td;
	reg [5:0] s03;
	reg [3:0] s04;
	reg [7:0] s05;
	reg [1:0] tmo;
	reg [7:0] d;
	wire [7:0] reg_addr;
	wire reg_wr;
	wire [7:0] reg_wdata;
	wire reg_rd;
	wire [7:0] reg_rdata;
	wire irq;
	integer err_count;
	integer n_tests;
	integer i;

	psib_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	psib_bank dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .temp_region(tr), .no_thermistor(nt),
		.thermistor_disabled(td), .charger_state(cs),
		.input_limit_active(s03[5]), .input_overvoltage(s03[4]),
		.input_valid(s03[3]), .charge_temp_shutdown(s03[2]),
		.charge_temp_regulation(s03[1]), .charge_timeout(s03[0]),
		.charger_thermal_shutdown(s04[3]), .oneshot_monitor_busy(s04[2]),
		.linear_switch_thermal(s04[1]), .second_linear_lockout(s04[0]),
		.buckboost_fault(s05[7]), .buckboost_lockout(s05[6]),
		.sysrail_charge_limit(s05[5]), .input_collapse_limit(s05[4]),
		.step_charge_active(s05[3]), .buck_one_thermal(s05[2]),
		.buck_two_thermal(s05[1]), .buck_three_thermal(s05[0]),
		.switch_one_start_timeout(tmo[1]),
		.switch_two_start_timeout(tmo[0]), .irq(irq));

	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task chk(input string name, input [7:0] seen, input [7:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Read one register and compare
	task rc(input [7:0] a, input [7:0] exp);
		host.rd(a, d);
		chk($sformatf("reg %h", a), d, exp);
	endtask

	// irq is combinational, so look away from the edge
	task chk_irq(input [7:0] exp);
		@(negedge clk);
		chk("irq", {7'h00, irq}, exp);
	endtask

	task results;
		if (err_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Cuts a hang short
	initial begin
		repeat (5000) @(posedge clk);
		err_count = err_count + 1;
		results;
	end

	initial begin
		// Reset bit on top, the 28 status bits below it all low
		{reset, tr, cs, nt, td, s03, s04, s05, tmo} = {1'b1, 28'h0};
		err_count = 0;
		n_tests = 0;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		rc(8'h00, `PSIB_IDENT_VAL);
		host.wr(8'h00, 8'hFF);
		rc(8'h00, `PSIB_IDENT_VAL);
		rc(8'h01, `PSIB_REV_VAL);
		rc(8'h20, 8'h00);
		rc(8'h09, 8'h00);
		host.wr(8'h09, 8'hA5);
		rc(8'h09, 8'hA5);
		rc(8'h02, 8'h38);
		rc(8'h07, 8'h00);
		rc(8'h08, 8'h00);
		rc(8'h06, 8'h80);
		rc(8'h06, 8'h00);
		// Masked event must not reach irq, unmasked one must
		host.wr(8'h09, 8'h00);
		@(posedge clk) s03 <= 6'h08;
		repeat (2) @(posedge clk);
		chk_irq(8'h00);
		host.wr(8'h09, 8'h08);
		chk_irq(8'h01);
		rc(8'h06, 8'h88);
		chk_irq(8'h00);
		@(posedge clk) s03 <= 6'h00;
		rc(8'h06, 8'h88);
		@(posedge clk) s03 <= 6'h08;
		// Every charger code, temperature regions cycling
		for (i = 0; i < 8; i = i + 1) begin
			@(posedge clk) cs <= 3'(i);
			tr <= 3'(i % 5);
			rc(8'h02, {2'b00, 3'(i % 5), 3'(i)});
		end
		@(posedge clk) nt <= 1'b1;
		rc(8'h02, 8'h2F);
		@(posedge clk) td <= 1'b1;
		rc(8'h02, 8'h37);
		@(posedge clk) s03 <= 6'h00;
		rc(8'h02, 8'h3F);
		// Region, state and input-valid changes since the last read
		rc(8'h06, 8'hC8);
		@(posedge clk) s03 <= 6'h2A;
		rc(8'h03, 8'h2A);
		// Only the toggled input bits and the region field may show
		rc(8'h06, 8'hAA);
		@(posedge clk) s03 <= 6'h15;
		rc(8'h03, 8'h15);
		@(posedge clk) s05 <= 8'hA5;
		rc(8'h05, 8'hA5);
		@(posedge clk) s05 <= 8'h5A;
		rc(8'h05, 8'h5A);
		@(posedge clk) s04 <= 4'hA;
		rc(8'h04, 8'hA0);
		@(posedge clk) s04 <= 4'h5;
		rc(8'h04, 8'h50);
		rc(8'h08, 8'hFF);
		rc(8'h08, 8'h00);
		@(posedge clk) s05 <= 8'hDB;
		rc(8'h08, 8'h81);
		rc(8'h07, 8'hF0);
		rc(8'h07, 8'h40);
		// One switch at a time, so swapped timeout bits show up
		@(posedge clk) tmo <= 2'h2;
		s04 <= 4'hD;
		@(posedge clk) tmo <= 2'h0;
		rc(8'h07, 8'hC2);
		@(posedge clk) tmo <= 2'h1;
		@(posedge clk) tmo <= 2'h0;
		rc(8'h07, 8'h41);
		results;
	end
endmodule
